// ==== rtl/rxc_pkg.sv ====
// Constants, types and carriers shared by the receiver module control port
package rxc_pkg;
  localparam int LANES = 12;
  localparam int NFLAG = 8;
  localparam int EVW = LANES + NFLAG;
  localparam logic [3:0] DEV_ADDR_HI = 4'h5;
  localparam logic [7:0] ADDR_FIRST = 8'h50;
  localparam logic [7:0] ADDR_LAST = 8'h5F;
  // Byte offsets of the serial register space
  localparam logic [7:0] OFF_STATUS = 8'h02;
  localparam logic [7:0] OFF_LOS_LO = 8'h03;
  localparam logic [7:0] OFF_LOS_HI = 8'h04;
  localparam logic [7:0] OFF_FLAG = 8'h05;
  localparam logic [7:0] OFF_REGRST = 8'h5B;
  localparam logic [7:0] OFF_CONFIG = 8'hE1;
  localparam int REGRST_BIT = 0;
  localparam int MODE_BIT = 0;
  localparam logic MODE_PULSE = 1'b0;
  localparam logic MODE_RESET = MODE_PULSE;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int CLK_NS = 4;
  localparam int ALERT_PULSE_NS = 1000;
  localparam int ALERT_PULSE_CYC = (ALERT_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_W = 16;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK, ST_WDATA, ST_RDATA, ST_RACK
  } rxc_state_e;

  // Pin levels that are sampled together through the synchroniser
  typedef struct packed {
    logic scl;
    logic sda;
    logic rst_n;
    logic [2:0] adr;
  } rxc_pins_s;

  // Lane events carried from the lane clock into the system clock
  typedef struct packed {
    logic [LANES-1:0] loss;
    logic [NFLAG-1:0] flag;
  } rxc_events_s;
endpackage

// ==== rtl/rxc_control_port.sv ====
// Two-wire management port, alert output and reset squelch of the receiver module
// Functional notes
// - Answer address 0101 followed by the three strap levels, then read/write bit.
// - Pull alert low on any lane input loss or any monitor flag.
// - Alert is pulse or static, host selectable; pulse after reset.
// - Alert only drives low, otherwise released for an external pull-up.
// - Squelch all twelve receive outputs while module reset is low.
// - Module reset low ignores serial commands and restores defaults, keeps stored settings.
// - Open module reset input reads as high, so it counts as deasserted.
// - Strapped address always lies in 50h to 5Fh.
// - Loss and flag bits stay latched until read, module reset or register reset.
// - Alert mode lives in bit 0 of configuration byte 225.
// - Nine clocks with data high then a start resets the serial interface.
module rxc_control_port
  import rxc_pkg::*;
#(
  parameter int unsigned PULSE_CYC_P = ALERT_PULSE_CYC
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic lane_clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [2:0] addr_strap_i,
  input wire logic module_reset_n_i,
  input wire logic [LANES-1:0] lane_loss_i,
  input wire logic [NFLAG-1:0] mon_flag_i,
  output logic alert_out_n_o,
  output logic alert_out_n_oe_o,
  output logic [LANES-1:0] lane_squelch_o
);
  // The pulse counter cannot hold a longer pulse, and one cycle cannot retrigger
  if (PULSE_CYC_P < 2 || PULSE_CYC_P >= (1 << PULSE_W)) begin : g_bad_pulse
    $error("PULSE_CYC_P out of range");
  end

  // Lane clock domain
  rxc_events_s ev_lane_reg;
  logic sq_meta_reg;
  logic [LANES-1:0] squelch_reg;
  logic held_reg;

  always_ff @(posedge lane_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ev_lane_reg <= '0;
      sq_meta_reg <= 1'b1;
      squelch_reg <= '1;
    end else begin
      ev_lane_reg <= '{loss: lane_loss_i, flag: mon_flag_i};
      sq_meta_reg <= held_reg;
      squelch_reg <= {LANES{sq_meta_reg}};
    end
  end
  assign lane_squelch_o = squelch_reg;

  // System clock domain: synchronisers; reset high keeps an open reset pin deasserted
  rxc_pins_s pins_s1_reg, pins_s2_reg;
  rxc_events_s ev_s1_reg, ev_s2_reg;
  logic scl_prev_reg, sda_prev_reg;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pins_s1_reg <= '{scl: 1'b1, sda: 1'b1, rst_n: 1'b1, adr: 3'h0};
      pins_s2_reg <= '{scl: 1'b1, sda: 1'b1, rst_n: 1'b1, adr: 3'h0};
      ev_s1_reg <= '0;
      ev_s2_reg <= '0;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      pins_s1_reg <= '{scl: scl_i, sda: sda_i, rst_n: module_reset_n_i, adr: addr_strap_i};
      pins_s2_reg <= pins_s1_reg;
      ev_s1_reg <= ev_lane_reg;
      ev_s2_reg <= ev_s1_reg;
      scl_prev_reg <= pins_s2_reg.scl;
      sda_prev_reg <= pins_s2_reg.sda;
    end
  end

  wire held = ~pins_s2_reg.rst_n;
  wire scl_rise = pins_s2_reg.scl & ~scl_prev_reg;
  wire scl_fall = ~pins_s2_reg.scl & scl_prev_reg;
  wire start_det = pins_s2_reg.scl & scl_prev_reg & sda_prev_reg & ~pins_s2_reg.sda;
  wire stop_det = pins_s2_reg.scl & scl_prev_reg & ~sda_prev_reg & pins_s2_reg.sda;
  wire bus_ok = ~held & ~start_det & ~stop_det;

  rxc_state_e state_reg;
  logic [3:0] cnt_reg;
  logic [7:0] shift_reg, ptr_reg;
  logic first_reg, rw_reg, sda_oe_reg, mode_reg;
  logic [LANES-1:0] los_reg;
  logic [NFLAG-1:0] flag_reg;
  logic [PULSE_W-1:0] pulse_cnt_reg;
  logic alert_oe_reg;

  wire [7:0] own_addr = {DEV_ADDR_HI, pins_s2_reg.adr, 1'b0};
  wire addr_match = shift_reg[7:1] == own_addr[7:1];
  wire byte_done = scl_fall & (cnt_reg == BITS_PER_BYTE);
  wire wr_commit = bus_ok & (state_reg == ST_WDATA) & byte_done & ~first_reg;
  wire rd_load = bus_ok & scl_fall & (((state_reg == ST_ACK) & rw_reg) | (state_reg == ST_RACK));
  wire any_set = |los_reg | |flag_reg;

  // Everything read is passed in, so the wire follows every register it shows
  function automatic logic [7:0] read_byte(input logic [7:0] off, input logic [LANES-1:0] input_signal_loss,
      input logic [NFLAG-1:0] fl, input logic al, input logic set, input logic md);
    unique case (off)
      OFF_STATUS: read_byte = {6'h00, al, set};
      OFF_LOS_LO: read_byte = input_signal_loss[7:0];
      OFF_LOS_HI: read_byte = {4'h0, input_signal_loss[LANES-1:8]};
      OFF_FLAG: read_byte = fl;
      OFF_CONFIG: read_byte = {7'h00, md};
      default: read_byte = 8'h00;
    endcase
  endfunction

  wire [7:0] rd_byte = read_byte(ptr_reg, los_reg, flag_reg, alert_oe_reg, any_set, mode_reg);

  // Serial slave; a start from any state restarts address reception
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      first_reg <= 1'b1;
      rw_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (held) begin
      state_reg <= ST_IDLE;
      sda_oe_reg <= 1'b0;
    end else if (start_det) begin
      state_reg <= ST_ADDR;
      cnt_reg <= 4'h0;
      sda_oe_reg <= 1'b0;
    end else if (stop_det) begin
      state_reg <= ST_IDLE;
      sda_oe_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          sda_oe_reg <= 1'b0;
        end
        ST_ADDR, ST_WDATA: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], pins_s2_reg.sda};
            cnt_reg <= 4'(cnt_reg + 4'h1);
          end else if (byte_done) begin
            if (state_reg == ST_ADDR) begin
              state_reg <= addr_match ? ST_ACK : ST_IDLE;
              sda_oe_reg <= addr_match;
              rw_reg <= shift_reg[0];
              first_reg <= 1'b1;
            end else begin
              state_reg <= ST_ACK;
              sda_oe_reg <= 1'b1;
              first_reg <= 1'b0;
              ptr_reg <= first_reg ? shift_reg : 8'(ptr_reg + 8'h01);
            end
          end
        end
        ST_ACK, ST_RACK: begin
          if (state_reg == ST_RACK && scl_rise && pins_s2_reg.sda) begin
            state_reg <= ST_IDLE;
          end else if (rd_load) begin
            state_reg <= ST_RDATA;
            sda_oe_reg <= ~rd_byte[7];
            shift_reg <= {rd_byte[6:0], 1'b0};
            cnt_reg <= 4'h1;
            ptr_reg <= 8'(ptr_reg + 8'h01);
          end else if (scl_fall) begin
            state_reg <= ST_WDATA;
            sda_oe_reg <= 1'b0;
            cnt_reg <= 4'h0;
          end
        end
        ST_RDATA: begin
          if (byte_done) begin
            state_reg <= ST_RACK;
            sda_oe_reg <= 1'b0;
          end else if (scl_fall) begin
            sda_oe_reg <= ~shift_reg[7];
            shift_reg <= {shift_reg[6:0], 1'b0};
            cnt_reg <= 4'(cnt_reg + 4'h1);
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Latched event bits; a new event in a read or register reset cycle survives the clear
  wire regrst = wr_commit & (ptr_reg == OFF_REGRST) & shift_reg[REGRST_BIT];
  wire clr_lo = rd_load & (ptr_reg == OFF_LOS_LO);
  wire clr_hi = rd_load & (ptr_reg == OFF_LOS_HI);
  wire clr_fl = rd_load & (ptr_reg == OFF_FLAG);
  wire [LANES-1:0] los_clr = {{(LANES-8){clr_hi}}, {8{clr_lo}}};
  wire [LANES-1:0] los_keep = regrst ? '0 : los_reg & ~los_clr;
  wire [NFLAG-1:0] flag_keep = regrst ? '0 : flag_reg & ~{NFLAG{clr_fl}};
  wire [LANES-1:0] los_next = held ? '0 : los_keep | ev_s2_reg.loss;
  wire [NFLAG-1:0] flag_next = held ? '0 : flag_keep | ev_s2_reg.flag;
  wire new_evt = |(los_next & ~los_reg) | |(flag_next & ~flag_reg);
  wire [PULSE_W-1:0] pulse_next = new_evt ? PULSE_W'(PULSE_CYC_P) :
      (pulse_cnt_reg != '0 ? PULSE_W'(pulse_cnt_reg - 1'b1) : pulse_cnt_reg);
  wire alert_next = mode_reg ? (|los_next | |flag_next) : (pulse_next != '0);

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      los_reg <= '0;
      flag_reg <= '0;
      pulse_cnt_reg <= '0;
      alert_oe_reg <= 1'b0;
      mode_reg <= MODE_RESET;
    end else begin
      los_reg <= los_next;
      flag_reg <= flag_next;
      pulse_cnt_reg <= pulse_next;
      alert_oe_reg <= alert_next;
      if (wr_commit && ptr_reg == OFF_CONFIG) begin
        mode_reg <= shift_reg[MODE_BIT];
      end
    end
  end

  // Open-drain: the driven level is always low, only the enable moves
  assign sda_o = 1'b0;
  assign sda_oe_o = sda_oe_reg;
  assign alert_out_n_o = 1'b0;
  assign alert_out_n_oe_o = alert_oe_reg;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      held_reg <= 1'b1;
    end else begin
      held_reg <= held;
    end
  end

  sequence s_addr_byte_done;
    state_reg == ST_ADDR && byte_done && bus_ok;
  endsequence

  a_held_releases_sda: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    held |=> !sda_oe_o && state_reg == ST_IDLE) else $error("data line driven in reset");
  a_addr_mismatch_nack: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    s_addr_byte_done and !addr_match |=> !sda_oe_o && state_reg == ST_IDLE)
    else $error("foreign address acknowledged");
  a_addr_match_ack: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    s_addr_byte_done and addr_match |=> sda_oe_o && state_reg == ST_ACK)
    else $error("own address not acknowledged");
  a_addr_in_range: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    own_addr >= ADDR_FIRST && own_addr <= ADDR_LAST) else $error("address outside range");
  a_static_alert: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    mode_reg && (|los_next || |flag_next) |=> alert_out_n_oe_o)
    else $error("static alert not driven");
  a_pulse_alert_width: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    !mode_reg && new_evt |=> alert_out_n_oe_o [*2]) else $error("alert pulse too short");
  a_pulse_alert_end: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    !mode_reg && pulse_cnt_reg == 1 && !new_evt |=> !alert_out_n_oe_o)
    else $error("alert pulse too long");
  a_latch_holds: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    los_reg[0] && !clr_lo && !held && !regrst |=> los_reg[0]) else $error("loss bit lost");
  a_squelch_on_reset: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    held [*3] |=> held_reg) else $error("squelch source not set");
endmodule

// ==== sim/rxc_host_model.sv ====
// Host controller model on the two-wire bus
module rxc_host_model (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Eight cycles a phase, twice the four that the port needs to sample safely
  task automatic tick();
    repeat (8) @(posedge clk_i);
    #1;
  endtask
  task automatic bit_x(input logic b, output logic r);
    tick();
    sda_o = b;
    tick();
    scl_o = 1'b1;
    tick();
    r = sda_i;
    scl_o = 1'b0;
  endtask
  task automatic start();
    tick();
    sda_o = 1'b1;
    tick();
    scl_o = 1'b1;
    tick();
    sda_o = 1'b0;
    tick();
    scl_o = 1'b0;
  endtask
  task automatic stop();
    tick();
    sda_o = 1'b0;
    tick();
    scl_o = 1'b1;
    tick();
    sda_o = 1'b1;
  endtask
  // MSB first; a byte of all ones releases the line so the slave can drive it
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ak);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(a, ak);
  endtask
  task automatic recover();
    logic r;
    for (int i = 0; i < 9; i++) bit_x(1'b1, r);
    start();
  endtask
endmodule

// ==== sim/tb_rxc_control_port.sv ====
// Self-checking bench of the receiver module control port
module tb_rxc_control_port import rxc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PC = 8;
  logic clk = 1'b0;
  logic lclk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] strap = 3'b101;
  logic mrst_n = 1'b1;
  logic [LANES-1:0] loss = '0;
  logic [NFLAG-1:0] flag = '0;
  logic h_scl, h_sda, sda_o, sda_oe, al_o, al_oe;
  logic [LANES-1:0] sq;
  logic [7:0] q;
  int n_fail = 0;
  int checks_done = 0;
  // Board pull-ups on both open-drain lines
  wire sda_pin = h_sda & ~(sda_oe & ~sda_o);
  wire al_pin = al_oe ? al_o : 1'b1;
  initial forever #2 clk = ~clk;
  initial begin
    #1;
    forever #15 lclk = ~lclk;
  end
  rxc_host_model i_rxc_host_model (.clk_i(clk), .sda_i(sda_pin), .scl_o(h_scl), .sda_o(h_sda));
  rxc_control_port #(.PULSE_CYC_P(PC)) i_rxc_control_port (.sys_clk_i(clk), .reset_i(reset),
    .lane_clk_i(lclk), .scl_i(h_scl), .sda_i(sda_pin), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .addr_strap_i(strap), .module_reset_n_i(mrst_n), .lane_loss_i(loss), .mon_flag_i(flag),
    .alert_out_n_o(al_o), .alert_out_n_oe_o(al_oe), .lane_squelch_o(sq));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wb(input logic [7:0] d, input logic e);
    logic [7:0] r;
    logic ak;
    i_rxc_host_model.xfer(d, 1'b1, r, ak);
    chk("ack", ak, e);
  endtask
  task automatic probe(input logic [6:0] a, input logic e);
    i_rxc_host_model.start();
    wb({a, 1'b0}, e);
    i_rxc_host_model.stop();
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    i_rxc_host_model.start();
    wb({DEV_ADDR_HI, strap, 1'b0}, 1'b0);
    wb(p, 1'b0);
    wb(d, 1'b0);
    i_rxc_host_model.stop();
  endtask
  task automatic rd(input logic [7:0] p);
    logic ak;
    i_rxc_host_model.start();
    wb({DEV_ADDR_HI, strap, 1'b0}, 1'b0);
    wb(p, 1'b0);
    i_rxc_host_model.start();
    wb({DEV_ADDR_HI, strap, 1'b1}, 1'b0);
    i_rxc_host_model.xfer(8'hFF, 1'b1, q, ak);
    i_rxc_host_model.stop();
  endtask
  task automatic ev(input logic [LANES-1:0] l, input logic [NFLAG-1:0] f);
    @(posedge lclk);
    loss <= l;
    flag <= f;
    repeat (3) @(posedge lclk);
    loss <= '0;
    flag <= '0;
  endtask
  task automatic wait_al(input logic v);
    int i;
    for (i = 0; i < 300 && al_pin !== v; i++) @(negedge clk);
    if (i == 300) begin
      chk("alert wait", al_pin, v);
      end_sim();
    end
  endtask
  task automatic t_reset();
    repeat (5) @(posedge clk);
    chk("squelch in reset", sq, {LANES{1'b1}});
    reset <= 1'b0;
    repeat (40) @(posedge clk);
    chk("squelch after reset", sq, '0);
  endtask
  task automatic t_addr();
    for (int s = 0; s < 8; s += 7) begin
      @(posedge clk);
      strap <= 3'(s);
      repeat (10) @(posedge clk);
      probe({DEV_ADDR_HI, 3'(s)}, 1'b0);
      probe({DEV_ADDR_HI, ~3'(s)}, 1'b1);
    end
    @(posedge clk);
    strap <= 3'b101;
  endtask
  task automatic t_pulse();
    int n;
    fork ev(12'h808, '0); join_none
    wait_al(1'b0);
    for (n = 0; n < 50 && al_pin === 1'b0; n++) @(negedge clk);
    chk("pulse width", 16'(n), 16'(PC));
    rd(OFF_LOS_LO);
    chk("loss latched", q, 8'h08);
    rd(OFF_LOS_LO);
    chk("loss cleared", q, 8'h00);
    rd(OFF_LOS_HI);
    chk("loss high latched", q, 8'h08);
  endtask
  task automatic t_static();
    wr(OFF_CONFIG, 8'h01);
    fork ev('0, 8'h20); join_none
    wait_al(1'b0);
    repeat (3 * PC) @(negedge clk);
    chk("static alert", al_pin, 1'b0);
    rd(OFF_STATUS);
    chk("status", q, 8'h03);
    rd(OFF_FLAG);
    chk("flag latched", q, 8'h20);
    repeat (10) @(negedge clk);
    chk("static release", al_pin, 1'b1);
  endtask
  task automatic t_regrst();
    fork ev(12'h800, '0); join_none
    wait_al(1'b0);
    wr(OFF_REGRST, 8'h01);
    wait_al(1'b1);
    rd(OFF_LOS_HI);
    chk("register reset", q, 8'h00);
  endtask
  task automatic t_recover();
    logic ak;
    i_rxc_host_model.start();
    wb({DEV_ADDR_HI, strap, 1'b0}, 1'b0);
    i_rxc_host_model.recover();
    wb({DEV_ADDR_HI, strap, 1'b1}, 1'b0);
    i_rxc_host_model.xfer(8'hFF, 1'b1, q, ak);
    i_rxc_host_model.stop();
  endtask
  task automatic t_mreset();
    fork ev(12'h001, '0); join_none
    wait_al(1'b0);
    @(posedge clk);
    mrst_n <= 1'b0;
    repeat (40) @(posedge clk);
    chk("module reset squelch", sq, {LANES{1'b1}});
    chk("module reset alert", al_pin, 1'b1);
    probe({DEV_ADDR_HI, strap}, 1'b1);
    @(posedge clk);
    mrst_n <= 1'b1;
    repeat (40) @(posedge clk);
    chk("squelch release", sq, '0);
    rd(OFF_LOS_LO);
    chk("loss after module reset", q, 8'h00);
    rd(OFF_CONFIG);
    chk("mode kept", q, 8'h01);
  endtask
  initial begin
    t_reset();
    t_addr();
    t_pulse();
    t_static();
    t_regrst();
    t_recover();
    t_mreset();
    end_sim();
  end
endmodule
